// ==== hw/debug_bridge_pkg.sv ====
package debug_bridge_pkg;
  // board clock and the fastest debug clock (divider field 00)
  localparam int CLK_HZ = 40_000_000;
  localparam int SCK_BASE_HZ = 10_000_000;
  localparam int HALF_W = 5;
  localparam logic [HALF_W-1:0] SCK_HALF_BASE =
    HALF_W'(CLK_HZ / (2 * SCK_BASE_HZ));
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic READY_LEVEL = 1'b0;

  // control / status byte layout
  localparam int CTRL_W = 5;
  localparam int DIV_LSB = 3;
  localparam int DIV_MSB = 4;
  localparam int STATREQ_BIT = 2;
  localparam int LOOPBACK_BIT = 1;
  localparam int ENTRY_BIT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // synchronised pin vector layout
  localparam int PIN_POWER = 0;
  localparam int PIN_ENABLE_N = 1;
  localparam int PIN_SEL_LSB = 2;
  localparam int PIN_SEL_MSB = 4;
  localparam int PIN_DC = 5;
  localparam int PIN_REQ = 6;
  localparam int PIN_ACK = 7;
  localparam int PIN_SOFT = 8;
  localparam int PIN_HARD = 9;
  localparam int PIN_WRITE = 10;
  localparam int PIN_PRST = 11;
  localparam int PIN_DEBUG = 12;
  localparam int PIN_SDO = 13;
  localparam int PIN_DATA_LSB = 14;
  localparam int PIN_DATA_MSB = 21;
  localparam int PIN_W = 22;

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_ACK = 1'b1
  } handshake_type;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_WAIT = 2'b01,
    SH_LOW = 2'b10,
    SH_HIGH = 2'b11
  } shift_type;
endpackage : debug_bridge_pkg

// ==== hw/serial_debug_shifter.sv ====
`timescale 1ns/1ps
module serial_debug_shifter
  import debug_bridge_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic [BYTE_W-1:0] tx_byte_in,
  input wire logic [1:0] divider_in,
  input wire logic loopback_in,
  input wire logic abort_in,
  input wire logic serial_debug_out_in,
  output logic busy_out,
  output logic done_out,
  output logic cut_out,
  output logic [BYTE_W-1:0] rx_byte_out,
  output logic serial_debug_clock_out,
  output logic serial_debug_in_out
);
  typedef struct packed {
    shift_type state;
    logic [HALF_W-1:0] cnt;
    logic [2:0] bit_idx;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] rx;
    logic sck;
    logic sdi;
    logic done;
    logic cut;
  } shifter_state_type;

  shifter_state_type st;
  shifter_state_type next_st;
  logic [HALF_W-1:0] half;
  logic in_bit;

  // half period of the debug clock from the divider field
  assign half = HALF_W'(SCK_HALF_BASE << divider_in);
  assign in_bit = loopback_in ? st.sdi : serial_debug_out_in;

  // bit engine: drive on falling edge, sample before it
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.cut = 1'b0;
    case (st.state)
      SH_IDLE: begin
        if (start_in) begin
          next_st.tx = tx_byte_in;
          next_st.bit_idx = 3'h0;
          next_st.state = SH_WAIT;
        end
      end
      SH_WAIT: begin
        // hold off until the port shows ready; in loopback go at once
        if (loopback_in || serial_debug_out_in == READY_LEVEL) begin
          next_st.sdi = st.tx[BYTE_W-1];
          next_st.cnt = half - 5'h01;
          next_st.state = SH_LOW;
        end
      end
      SH_LOW: begin
        if (st.cnt == 5'h00) begin
          next_st.sck = 1'b1;
          next_st.cnt = half - 5'h01;
          next_st.state = SH_HIGH;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      SH_HIGH: begin
        if (st.cnt == 5'h00) begin
          next_st.rx = {st.rx[BYTE_W-2:0], in_bit};
          next_st.sck = 1'b0;
          if (st.bit_idx == LAST_BIT) begin
            next_st.done = 1'b1;
            next_st.state = SH_IDLE;
          end else begin
            next_st.bit_idx = st.bit_idx + 3'h1;
            next_st.tx = {st.tx[BYTE_W-2:0], 1'b0};
            next_st.sdi = st.tx[BYTE_W-2];
            next_st.cnt = half - 5'h01;
            next_st.state = SH_LOW;
          end
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      default: next_st.state = SH_IDLE;
    endcase
    // a processor reset cuts a running byte
    if (abort_in && st.state != SH_IDLE) begin
      next_st.cut = 1'b1;
      next_st.done = 1'b0;
      next_st.sck = 1'b0;
      next_st.state = SH_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = st.state != SH_IDLE;
  assign done_out = st.done;
  assign cut_out = st.cut;
  assign rx_byte_out = st.rx;
  assign serial_debug_clock_out = st.sck;
  assign serial_debug_in_out = st.sdi;

  // helper: length of the last high phase
  logic [HALF_W:0] hi_len;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hi_len <= '0;
    end else if (st.sck) begin
      hi_len <= hi_len + 6'h01;
    end else begin
      hi_len <= '0;
    end
  end

  property p_sdi_on_fall;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(st.sck) |-> $stable(st.sdi);
  endproperty
  a_sdi_on_fall: assert property (p_sdi_on_fall)
    else $error("data-in changed on a rising debug clock");

  property p_half_period;
    @(posedge clk_in) disable iff (!reset_n_in)
      ($fell(st.sck) && !$past(abort_in)) |->
        hi_len == {1'b0, $past(half)};
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("debug clock high phase has the wrong length");

  sequence s_not_ready;
    st.state == SH_WAIT && !loopback_in &&
      serial_debug_out_in != READY_LEVEL && !abort_in;
  endsequence
  property p_wait_ready;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_not_ready |=> st.state == SH_WAIT && !st.sck;
  endproperty
  a_wait_ready: assert property (p_wait_ready)
    else $error("transfer began before the port was ready");

  property p_sample_on_fall;
    @(posedge clk_in) disable iff (!reset_n_in)
      (st.state == SH_HIGH && st.cnt == 5'h00 && !abort_in) |=>
        st.rx[0] == $past(in_bit) && !st.sck;
  endproperty
  a_sample_on_fall: assert property (p_sample_on_fall)
    else $error("data-out bit not captured at end of high phase");
endmodule : serial_debug_shifter

// ==== hw/host_port_debug_serial_bridge.sv ====
`timescale 1ns/1ps
module host_port_debug_serial_bridge
  import debug_bridge_pkg::*;
#(
  parameter logic [2:0] BOARD_ADDRESS = 3'h0
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic host_power_sense_in,
  input wire logic host_enable_n_in,
  input wire logic [2:0] board_address_select_in,
  input wire logic data_control_select_in,
  input wire logic host_write_in,
  input wire logic host_request_in,
  input wire logic host_side_acknowledge_in,
  input wire logic host_soft_reset_request_in,
  input wire logic host_hard_reset_request_in,
  input wire logic [BYTE_W-1:0] parallel_data_bus_in,
  output logic [BYTE_W-1:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe_n_out,
  output logic board_side_request_out,
  output logic board_side_acknowledge_out,
  output logic serial_debug_clock_out,
  output logic serial_debug_in_out,
  output logic serial_debug_in_oe_n_out,
  input wire logic serial_debug_out_in,
  input wire logic processor_in_reset_in,
  input wire logic processor_in_debug_in,
  output logic soft_reset_out,
  output logic soft_reset_oe_n_out,
  output logic hard_reset_out,
  output logic hard_reset_oe_n_out,
  output logic debug_entry_out
);
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    handshake_type hs;
    logic [CTRL_W-1:0] ctrl;
    logic [BYTE_W-1:0] data;
    logic [BYTE_W-1:0] bus_out;
    logic bus_drive;
    logic start;
    logic rx_pending;
    logic tx_error;
    logic soft_rst;
    logic hard_rst;
  } bridge_state_type;

  bridge_state_type st;
  bridge_state_type next_st;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] p;
  logic powered;
  logic selected;
  logic host_req;
  logic is_write;
  logic is_data;
  logic [BYTE_W-1:0] host_byte;
  logic [BYTE_W-1:0] status_byte;
  logic busy;
  logic done;
  logic cut;
  logic [BYTE_W-1:0] rx_byte;
  logic loopback;

  // every pin crosses two flip-flops before use
  assign pins = {parallel_data_bus_in, serial_debug_out_in,
                 processor_in_debug_in, processor_in_reset_in,
                 host_write_in, host_hard_reset_request_in,
                 host_soft_reset_request_in, host_side_acknowledge_in,
                 host_request_in, data_control_select_in,
                 board_address_select_in, host_enable_n_in,
                 host_power_sense_in};
  assign p = st.sync2;

  // board selection qualifiers
  assign powered = p[PIN_POWER];
  assign selected = powered && !p[PIN_ENABLE_N] &&
    p[PIN_SEL_MSB:PIN_SEL_LSB] == BOARD_ADDRESS;
  assign host_req = p[PIN_REQ];
  assign is_write = p[PIN_WRITE];
  assign is_data = p[PIN_DC];
  assign host_byte = p[PIN_DATA_MSB:PIN_DATA_LSB];
  assign status_byte = {p[PIN_PRST], st.tx_error, p[PIN_DEBUG], st.ctrl};
  assign loopback = !st.ctrl[LOOPBACK_BIT];

  // register file, handshake and reset requests
  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.start = 1'b0;
    next_st.soft_rst = selected && p[PIN_SOFT];
    next_st.hard_rst = selected && p[PIN_HARD];
    // host acknowledge retires a pending receive request
    if (powered && p[PIN_ACK]) begin
      next_st.rx_pending = 1'b0;
    end
    case (st.hs)
      HS_IDLE: begin
        next_st.bus_drive = 1'b0;
        if (selected && host_req) begin
          if (!is_write) begin
            // read: data or control/status by the select line
            next_st.bus_out = is_data ? st.data : status_byte;
            next_st.bus_drive = 1'b1;
            if (is_data) begin
              next_st.rx_pending = 1'b0;
            end
            next_st.hs = HS_ACK;
          end else if (!is_data) begin
            next_st.ctrl = host_byte[CTRL_W-1:0];
            next_st.hs = HS_ACK;
          end else if (!busy && !done && !st.start) begin
            // data write launches a serial byte; not while rx lands
            next_st.data = host_byte;
            next_st.start = 1'b1;
            next_st.tx_error = 1'b0;
            next_st.hs = HS_ACK;
          end
        end
      end
      HS_ACK: begin
        // hold acknowledge until the host drops its request or the board is deselected
        if (!host_req || !selected) begin
          next_st.hs = HS_IDLE;
          next_st.bus_drive = 1'b0;
        end
      end
      default: next_st.hs = HS_IDLE;
    endcase
    // received byte returns to the data register; set wins
    if (done) begin
      next_st.data = rx_byte;
      next_st.rx_pending = 1'b1;
    end
    if (cut) begin
      next_st.tx_error = 1'b1;
    end
    // host powered off: drop every host-side action
    if (!powered) begin
      next_st.hs = HS_IDLE;
      next_st.bus_drive = 1'b0;
      next_st.start = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  serial_debug_shifter u_shifter (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(st.start),
    .tx_byte_in(st.data),
    .divider_in(st.ctrl[DIV_MSB:DIV_LSB]),
    .loopback_in(loopback),
    .abort_in(p[PIN_PRST]),
    .serial_debug_out_in(p[PIN_SDO]),
    .busy_out(busy),
    .done_out(done),
    .cut_out(cut),
    .rx_byte_out(rx_byte),
    .serial_debug_clock_out(serial_debug_clock_out),
    .serial_debug_in_out(serial_debug_in_out)
  );

  // host-facing outputs
  assign parallel_data_bus_out = st.bus_out;
  assign parallel_data_bus_oe_n_out = !st.bus_drive;
  assign board_side_acknowledge_out = st.hs == HS_ACK;
  assign board_side_request_out = powered &&
    (!st.ctrl[STATREQ_BIT] || st.rx_pending);
  // processor-facing outputs; the two resets are open drain, pulled low when active
  assign serial_debug_in_oe_n_out = loopback;
  assign soft_reset_out = 1'b0;
  assign soft_reset_oe_n_out = !st.soft_rst;
  assign hard_reset_out = 1'b0;
  assign hard_reset_oe_n_out = !st.hard_rst;
  assign debug_entry_out = !st.ctrl[ENTRY_BIT];

  property p_soft_reset;
    @(posedge clk_in) disable iff (!reset_n_in)
      (selected && p[PIN_SOFT]) |=> !soft_reset_oe_n_out;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset not driven for selected request");

  property p_hard_reset;
    @(posedge clk_in) disable iff (!reset_n_in)
      (selected && p[PIN_HARD]) |=> !hard_reset_oe_n_out;
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset not driven for selected request");

  property p_ack_needs_select;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(board_side_acknowledge_out) |-> $past(selected);
  endproperty
  a_ack_needs_select: assert property (p_ack_needs_select)
    else $error("acknowledge raised while not selected");

  property p_power_off;
    @(posedge clk_in) disable iff (!reset_n_in)
      !powered |=> !board_side_acknowledge_out &&
        parallel_data_bus_oe_n_out && !st.start;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("host side active while host unpowered");

  sequence s_data_read;
    st.hs == HS_IDLE && selected && host_req && !is_write && is_data;
  endsequence
  property p_data_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_data_read |=> parallel_data_bus_out == $past(st.data) &&
        !parallel_data_bus_oe_n_out;
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data register read returned wrong byte");

  sequence s_ack_held;
    board_side_acknowledge_out && host_req && selected;
  endsequence
  property p_four_phase;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_ack_held |=> board_side_acknowledge_out;
  endproperty
  a_four_phase: assert property (p_four_phase)
    else $error("acknowledge dropped before host request");

  property p_status_request;
    @(posedge clk_in) disable iff (!reset_n_in)
      (st.hs == HS_IDLE && selected && host_req && is_write && !is_data &&
        !host_byte[STATREQ_BIT]) |=> board_side_request_out;
  endproperty
  a_status_request: assert property (p_status_request)
    else $error("status request bit did not raise board request");
endmodule : host_port_debug_serial_bridge

// ==== testbench/debug_port_model.sv ====
`timescale 1ns/1ps
module debug_port_model
  import debug_bridge_pkg::*;
#(
  parameter logic [BYTE_W-1:0] REPLY = 8'h5a
)
(
  input wire logic clk_in,
  input wire logic in_reset_in,
  input wire logic ready_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic [BYTE_W-1:0] got_out,
  output int high_out,
  output int bad_edge_out
);
  logic [3:0] rises = 4'h0;
  logic [BYTE_W-1:0] shift = 8'h00;
  logic sck_q = 1'b0;
  logic sdi_q = 1'b0;
  logic sdo = ~READY_LEVEL;
  logic [BYTE_W-1:0] got = 8'h00;
  int run = 0;
  int high = 0;
  int bad_edge = 0;

  // busy until the bench says the port is ready
  assign sdo_out = sdo;
  assign got_out = got;
  assign high_out = high;
  assign bad_edge_out = bad_edge;

  // processor side of the link, looked at on every board clock
  always @(posedge clk_in) begin
    if (sck_in && sdi_in !== sdi_q) begin
      bad_edge++;
    end
    if (in_reset_in) begin
      rises = 4'h0;
      sdo <= ~READY_LEVEL;
    end else if (sck_in && !sck_q) begin
      shift = {shift[BYTE_W-2:0], sdi_in};
      rises = rises + 4'h1;
      run = 1;
    end else if (sck_in) begin
      run++;
    end else if (sck_q) begin
      high = run;
      if (rises == 4'h8) begin
        got = shift;
        rises = 4'h0;
      end else begin
        sdo <= REPLY[3'(4'h7 - rises)];
      end
    end
    if (rises == 4'h0 && !in_reset_in && !sck_in) begin
      sdo <= ready_in ? READY_LEVEL : ~READY_LEVEL;
    end
    sck_q = sck_in;
    sdi_q = sdi_in;
  end
endmodule : debug_port_model

// ==== testbench/host_port_debug_serial_bridge_test.sv ====
`timescale 1ns/1ps
module host_port_debug_serial_bridge_test;
  import debug_bridge_pkg::*;
  localparam logic [2:0] ADDR = 3'h5;
  localparam logic [BYTE_W-1:0] REPLY = 8'h5a;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic host_power_sense_in = 1'b1;
  logic host_enable_n_in = 1'b0;
  logic [2:0] board_address_select_in = ADDR;
  logic data_control_select_in = 1'b0;
  logic host_write_in = 1'b0;
  logic host_request_in = 1'b0;
  logic host_side_acknowledge_in = 1'b0;
  logic host_soft_reset_request_in = 1'b0;
  logic host_hard_reset_request_in = 1'b0;
  logic [BYTE_W-1:0] parallel_data_bus_in = 8'h00;
  logic processor_in_reset_in = 1'b0;
  logic processor_in_debug_in = 1'b0;
  logic [BYTE_W-1:0] parallel_data_bus_out, got, rd;
  logic parallel_data_bus_oe_n_out, board_side_request_out;
  logic board_side_acknowledge_out, serial_debug_clock_out;
  logic serial_debug_in_out, serial_debug_in_oe_n_out;
  logic serial_debug_out_in, soft_reset_out, soft_reset_oe_n_out;
  logic hard_reset_out, hard_reset_oe_n_out, debug_entry_out;
  logic ready = 1'b1;
  logic moved = 1'b0;
  logic sdi_wire;
  int high_cycles, bad_edges, cycles = 0;
  int bad_count = 0;
  int tests_run = 0;

  always #12.5 clk_in = ~clk_in;

  // data-in wire has a pull-down while nobody drives it
  assign sdi_wire = serial_debug_in_oe_n_out ? 1'b0 : serial_debug_in_out;

  host_port_debug_serial_bridge #(.BOARD_ADDRESS(ADDR)) DUT (.clk_in,
    .reset_n_in, .host_power_sense_in, .host_enable_n_in,
    .board_address_select_in, .data_control_select_in, .host_write_in,
    .host_request_in, .host_side_acknowledge_in,
    .host_soft_reset_request_in, .host_hard_reset_request_in,
    .parallel_data_bus_in, .parallel_data_bus_out,
    .parallel_data_bus_oe_n_out, .board_side_request_out,
    .board_side_acknowledge_out, .serial_debug_clock_out,
    .serial_debug_in_out, .serial_debug_in_oe_n_out, .serial_debug_out_in,
    .processor_in_reset_in, .processor_in_debug_in, .soft_reset_out,
    .soft_reset_oe_n_out, .hard_reset_out, .hard_reset_oe_n_out,
    .debug_entry_out);

  debug_port_model #(.REPLY(REPLY)) processor (.clk_in,
    .in_reset_in(processor_in_reset_in), .ready_in(ready),
    .sck_in(serial_debug_clock_out), .sdi_in(sdi_wire),
    .sdo_out(serial_debug_out_in), .got_out(got), .high_out(high_cycles),
    .bad_edge_out(bad_edges));

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_in);
  endtask : ticks

  // one four-phase host transfer; want says whether an answer is due
  task automatic access(input logic wr, input logic dc,
    input logic [7:0] wd, input logic want);
    int n;
    n = 0;
    host_write_in <= wr;
    data_control_select_in <= dc;
    parallel_data_bus_in <= wd;
    host_request_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (board_side_acknowledge_out !== 1'b1 && n < (want ? 700 : 12));
    rd = parallel_data_bus_out;
    check("ack", {7'h00, board_side_acknowledge_out}, {7'h00, want});
    if (want) begin
      check("bus drive", {7'h00, parallel_data_bus_oe_n_out}, {7'h00, wr});
    end
    host_request_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (board_side_acknowledge_out !== 1'b0 && n < 12);
    check("ack drop", {7'h00, board_side_acknowledge_out}, 8'h00);
  endtask : access

  task automatic rd_ctrl(input logic [7:0] exp);
    access(1'b0, 1'b0, 8'h00, 1'b1);
    check("status", rd, exp);
  endtask : rd_ctrl

  task automatic wait_req;
    int n;
    n = 0;
    while (board_side_request_out !== 1'b1 && n < 900) begin
      @(posedge clk_in);
      n++;
    end
    check("byte done", {7'h00, board_side_request_out}, 8'h01);
  endtask : wait_req

  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // test sequence
  initial begin
    ticks(12);
    reset_n_in <= 1'b1;
    ticks(4);
    check("idle pins", {board_side_acknowledge_out, parallel_data_bus_oe_n_out,
      serial_debug_clock_out, soft_reset_oe_n_out, hard_reset_oe_n_out,
      debug_entry_out, serial_debug_in_oe_n_out, board_side_request_out},
      8'h5f);
    rd_ctrl(8'h00);
    $display("test reset done");
    access(1'b1, 1'b0, 8'h04, 1'b1);
    check("request off", {7'h00, board_side_request_out}, 8'h00);
    access(1'b1, 1'b1, 8'ha5, 1'b1);
    wait_req();
    access(1'b0, 1'b1, 8'h00, 1'b1);
    check("loopback", rd, 8'ha5);
    check("sdi float", {7'h00, serial_debug_in_oe_n_out}, 8'h01);
    $display("test loopback done");
    for (int d = 0; d < 4; d++) begin
      processor_in_debug_in <= d[0];
      access(1'b1, 1'b0, {3'h0, d[1:0], 3'b111}, 1'b1);
      rd_ctrl({2'b00, d[0], d[1:0], 3'b111});
      access(1'b1, 1'b1, 8'h3c ^ 8'(d), 1'b1);
      wait_req();
      check("byte seen", got, 8'h3c ^ 8'(d));
      check("half period", 8'(high_cycles), 8'(SCK_HALF_BASE) << d);
      access(1'b0, 1'b1, 8'h00, 1'b1);
      check("byte back", rd, {READY_LEVEL, REPLY[BYTE_W-2:0]});
    end
    $display("test dividers done");
    ready <= 1'b0;
    access(1'b1, 1'b1, 8'h81, 1'b1);
    repeat (60) begin
      @(posedge clk_in);
      if (serial_debug_clock_out !== 1'b0) moved = 1'b1;
    end
    check("held clock", {7'h00, moved}, 8'h00);
    ready <= 1'b1;
    wait_req();
    check("byte seen", got, 8'h81);
    host_side_acknowledge_in <= 1'b1;
    ticks(4);
    host_side_acknowledge_in <= 1'b0;
    check("request cleared", {7'h00, board_side_request_out}, 8'h00);
    access(1'b1, 1'b1, 8'hff, 1'b1);
    ticks(40);
    processor_in_reset_in <= 1'b1;
    ticks(10);
    rd_ctrl(8'hff);
    processor_in_reset_in <= 1'b0;
    ticks(6);
    access(1'b0, 1'b1, 8'h00, 1'b1);
    access(1'b1, 1'b1, 8'h42, 1'b1);
    wait_req();
    check("byte seen", got, 8'h42);
    access(1'b0, 1'b1, 8'h00, 1'b1);
    rd_ctrl(8'h3f);
    $display("test ready and abort done");
    host_soft_reset_request_in <= 1'b1;
    ticks(5);
    check("soft", {6'h00, soft_reset_oe_n_out, soft_reset_out}, 8'h00);
    host_hard_reset_request_in <= 1'b1;
    ticks(5);
    check("hard", {6'h00, hard_reset_oe_n_out, hard_reset_out}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      board_address_select_in <= (k == 0) ? 3'h4 : ADDR;
      host_enable_n_in <= (k == 1);
      host_power_sense_in <= (k != 2);
      ticks(5);
      check("held off", {6'h00, soft_reset_oe_n_out, hard_reset_oe_n_out},
        8'h03);
      access(1'b0, 1'b0, 8'h00, 1'b0);
    end
    host_power_sense_in <= 1'b1;
    host_soft_reset_request_in <= 1'b0;
    host_hard_reset_request_in <= 1'b0;
    ticks(5);
    check("edge order", 8'(bad_edges), 8'h00);
    access(1'b1, 1'b0, 8'h1b, 1'b1);
    check("status request", {7'h00, board_side_request_out}, 8'h01);
    $display("test selection done");
    final_report();
  end
endmodule : host_port_debug_serial_bridge_test
